/* File: design/cap_pwm_unit.sv */
// One capture/compare module: mode, compare value, match and 16-bit PWM.
`timescale 1ns/1ps
module cap_pwm_unit
  import cap_pkg::*;
#(
  parameter int W = CAP_CNT_W
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         mode_wr,
  input  wire logic         lo_wr,
  input  wire logic         hi_wr,
  input  wire logic [7:0]   wdata,
  input  wire logic [W-1:0] cnt,
  input  wire logic         tick,
  input  wire logic         wrap,
  output logic [7:0]        mode,
  output logic [W-1:0]      value,
  output logic              match,
  output logic              pwm_out
);

  logic [7:0]   mode_r;
  logic [W-1:0] value_r;
  logic         pwm_r;
  logic         wide_pwm;
  logic         hit;
  logic         wrap_seen_r;

  assign mode    = mode_r;
  assign value   = value_r;
  assign pwm_out = pwm_r;

  // Wide PWM only when all three enables are set.
  assign wide_pwm = mode_r[CAP_MODE_CMP_BIT] & mode_r[CAP_MODE_PWM_BIT]
                  & mode_r[CAP_MODE_WIDE_BIT];

  // A match is seen once per counter step that lands on the value.
  assign hit   = tick & mode_r[CAP_MODE_CMP_BIT] & (cnt == value_r);
  assign match = hit;

  // Mode register; a high value byte write sets and a low one clears compare enable as a side effect.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= CAP_MODE_RST;
    end else if (mode_wr) begin
      mode_r <= wdata;
    end else if (hi_wr) begin
      mode_r[CAP_MODE_CMP_BIT] <= 1'b1;
    end else if (lo_wr) begin
      mode_r[CAP_MODE_CMP_BIT] <= 1'b0;
    end
  end

  // Compare value, written a byte at a time.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= CAP_VAL_RST;
    end else begin
      if (lo_wr) begin
        value_r[7:0] <= wdata;
      end
      if (hi_wr) begin
        value_r[W-1:8] <= wdata[W-9:0];
      end
    end
  end

  // The overflow is acted on once the counter already reads zero, so the fall
  // trails the FFFF count by two steps while the rise trails the match by one.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrap_seen_r <= 1'b0;
    end else begin
      wrap_seen_r <= wrap;
    end
  end

  // Output is high from the match to the overflow, so the low time equals
  // the compare value in counter steps. The match wins a tie, which keeps
  // a value of zero at full duty. Held low outside the mode.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_r <= 1'b0;
    end else if (!wide_pwm) begin
      pwm_r <= 1'b0;
    end else if (hit) begin
      pwm_r <= 1'b1;
    end else if (wrap_seen_r) begin
      pwm_r <= 1'b0;
    end
  end

endmodule

/* File: design/cap_top.sv */
// Counter array with six compare modules in 16-bit PWM mode.
//
// Operation
// - In wide PWM mode the compare value sets the low time in counts.
// - In wide PWM mode the output goes high when counter equals value.
// - In wide PWM mode the output goes low when the counter overflows.
// - Wide PWM needs compare enable, PWM select and wide select all set.
// - Duty cycle is 65536 minus the value, over 65536.
// - Writing the low value byte clears compare enable.
// - Writing the high value byte sets compare enable.
// - Control bit 7 is set when the counter wraps from FFFF to 0000.
// - With overflow interrupt enabled, a set overflow flag requests service.
// - Hardware never clears flags; software clears them by writing zero.
// - Control bit 6 runs the counter when one, stops it when zero.
// - Control bit n is set on a match in module n, n 0 to 5.
// - With a module interrupt enabled, its set flag requests service.
`timescale 1ns/1ps
module cap_top
  import cap_pkg::*;
#(
  parameter int NUM_MOD = CAP_NUM_MOD,
  parameter int CNT_W   = CAP_CNT_W
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [7:0]         sfr_wdata,
  output logic [7:0]              sfr_rdata,
  output logic [NUM_MOD-1:0]      pwm_output_n,
  output logic                    overflow_irq_req,
  output logic                    match_irq_req
);

  // Counter and its control.
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic               counter_run;
  logic               tick;
  logic               wrap;

  // Control register pieces.
  logic               counter_overflow_flag_r;
  logic               counter_run_r;
  logic [NUM_MOD-1:0] module_event_flag_r;
  logic [NUM_MOD-1:0] flag_nxt;
  logic               ovf_nxt;

  // Array mode register holds the overflow interrupt enable.
  logic [7:0]         arr_mode_r;

  // Register port decode.
  logic               ctrl_wr;
  logic               arr_mode_wr;
  logic               cnt_lo_wr;
  logic               cnt_hi_wr;
  logic [NUM_MOD-1:0] mode_wr;
  logic [NUM_MOD-1:0] lo_wr;
  logic [NUM_MOD-1:0] hi_wr;

  // Per-module results.
  logic [7:0]         mod_mode  [NUM_MOD];
  logic [CNT_W-1:0]   mod_value [NUM_MOD];
  logic [NUM_MOD-1:0] mod_match;
  logic [NUM_MOD-1:0] mod_pwm;
  logic [NUM_MOD-1:0] mod_ie;

  // Read path and registered outputs.
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic [NUM_MOD-1:0] pwm_r;
  logic               ovf_irq_r;
  logic               match_irq_r;

  assign sfr_rdata        = rdata_r;
  assign pwm_output_n     = pwm_r;
  assign overflow_irq_req = ovf_irq_r;
  assign match_irq_req    = match_irq_r;

  // Fixed-address write strobes.
  assign ctrl_wr     = sfr_wr & (sfr_addr == CAP_CTRL_ADDR);
  assign arr_mode_wr = sfr_wr & (sfr_addr == CAP_ARR_MODE_ADDR);
  assign cnt_lo_wr   = sfr_wr & (sfr_addr == CAP_CNT_LO_ADDR);
  assign cnt_hi_wr   = sfr_wr & (sfr_addr == CAP_CNT_HI_ADDR);

  // Per-module write strobes, one slot per module in each block.
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) begin
      mode_wr[i] = sfr_wr & cap_hit(sfr_addr, CAP_MOD_MODE_BASE, i);
      lo_wr[i]   = sfr_wr & cap_hit(sfr_addr, CAP_VAL_LO_BASE, i);
      hi_wr[i]   = sfr_wr & cap_hit(sfr_addr, CAP_VAL_HI_BASE, i);
    end
  end

  // The counter steps once per clock while the run bit is set.
  assign counter_run = counter_run_r;
  assign tick        = counter_run;
  assign wrap        = tick & (cnt_r == CAP_CNT_MAX);

  // Next count. A software write to a counter byte overrides the step,
  // so a loaded value is not skewed by one count. The other byte keeps
  // its old value, so no carry leaks into a byte that was not written.
  always_comb begin
    cnt_nxt = cnt_r;
    if (tick && !cnt_lo_wr && !cnt_hi_wr) begin
      cnt_nxt = CNT_W'(cnt_r + 1'b1);
    end
    if (cnt_lo_wr) begin
      cnt_nxt[7:0] = sfr_wdata;
    end
    if (cnt_hi_wr) begin
      cnt_nxt[CNT_W-1:8] = sfr_wdata[CNT_W-9:0];
    end
  end

  // Counter register.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= CAP_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Compare modules; each sees the count that is current in this cycle.
  for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
    cap_pwm_unit #(
      .W (CNT_W)
    ) u_unit (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .mode_wr (mode_wr[g]),
      .lo_wr   (lo_wr[g]),
      .hi_wr   (hi_wr[g]),
      .wdata   (sfr_wdata),
      .cnt     (cnt_r),
      .tick    (tick),
      .wrap    (wrap),
      .mode    (mod_mode[g]),
      .value   (mod_value[g]),
      .match   (mod_match[g]),
      .pwm_out (mod_pwm[g])
    );
    assign mod_ie[g] = mod_mode[g][CAP_MODE_IE_BIT];
  end

  // Flag next values. A software write loads the written bits, then a
  // hardware event in the same cycle sets its bit again, so no event is
  // lost to a clear. Nothing here ever clears a flag by itself.
  always_comb begin
    ovf_nxt  = counter_overflow_flag_r;
    flag_nxt = module_event_flag_r;
    if (ctrl_wr) begin
      ovf_nxt  = sfr_wdata[CAP_CTRL_OVF_BIT];
      flag_nxt = sfr_wdata[NUM_MOD-1:0];
    end
    if (wrap) begin
      ovf_nxt = 1'b1;
    end
    flag_nxt = flag_nxt | mod_match;
  end

  // Control register state.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      counter_overflow_flag_r <= CAP_CTRL_RST[CAP_CTRL_OVF_BIT];
      counter_run_r           <= CAP_CTRL_RST[CAP_CTRL_RUN_BIT];
      module_event_flag_r     <= CAP_CTRL_RST[NUM_MOD-1:0];
    end else begin
      counter_overflow_flag_r <= ovf_nxt;
      module_event_flag_r     <= flag_nxt;
      if (ctrl_wr) begin
        counter_run_r <= sfr_wdata[CAP_CTRL_RUN_BIT];
      end
    end
  end

  // Array mode register; only the overflow interrupt enable acts.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      arr_mode_r <= CAP_MODE_RST;
    end else if (arr_mode_wr) begin
      arr_mode_r <= sfr_wdata;
    end
  end

  // Interrupt requests are levels that follow the flags and enables.
  // They drop only when software clears the flag or the enable.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_irq_r   <= 1'b0;
      match_irq_r <= 1'b0;
    end else begin
      ovf_irq_r   <= counter_overflow_flag_r
                   & arr_mode_r[CAP_ARR_OVF_IE_BIT];
      match_irq_r <= |(module_event_flag_r & mod_ie);
    end
  end

  // PWM pins are retimed once so every output leaves a flip-flop.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_r <= '0;
    end else begin
      pwm_r <= mod_pwm;
    end
  end

  // Read mux. Unmapped addresses read as zero; reads have no side effect.
  always_comb begin
    rdata_nxt = CAP_RD_UNMAP;
    unique case (sfr_addr)
      CAP_CTRL_ADDR: begin
        rdata_nxt                   = '0;
        rdata_nxt[CAP_CTRL_OVF_BIT] = counter_overflow_flag_r;
        rdata_nxt[CAP_CTRL_RUN_BIT] = counter_run_r;
        rdata_nxt[NUM_MOD-1:0]      = module_event_flag_r;
      end
      CAP_ARR_MODE_ADDR: begin
        rdata_nxt = arr_mode_r;
      end
      CAP_CNT_LO_ADDR: begin
        rdata_nxt = cnt_r[7:0];
      end
      CAP_CNT_HI_ADDR: begin
        rdata_nxt = cnt_r[CNT_W-1:8];
      end
      default: begin
        for (int i = 0; i < NUM_MOD; i++) begin
          if (cap_hit(sfr_addr, CAP_MOD_MODE_BASE, i)) begin
            rdata_nxt = mod_mode[i];
          end
          if (cap_hit(sfr_addr, CAP_VAL_LO_BASE, i)) begin
            rdata_nxt = mod_value[i][7:0];
          end
          if (cap_hit(sfr_addr, CAP_VAL_HI_BASE, i)) begin
            rdata_nxt = mod_value[i][CNT_W-1:8];
          end
        end
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next one,
  // so the port never shows a half-decoded address.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= CAP_RD_UNMAP;
    end else if (sfr_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule

/* File: inc/cap_pkg.sv */
// Constants, register map and decode helpers for the counter array PWM block.
package cap_pkg;

  // Geometry of the array.
  localparam int CAP_NUM_MOD = 6;
  localparam int CAP_CNT_W   = 16;

  // Register offsets on the special function register port.
  localparam logic [7:0] CAP_CTRL_ADDR      = 8'hD8;
  localparam logic [7:0] CAP_ARR_MODE_ADDR  = 8'hD9;
  localparam logic [7:0] CAP_CNT_LO_ADDR    = 8'hE8;
  localparam logic [7:0] CAP_CNT_HI_ADDR    = 8'hE9;
  localparam logic [7:0] CAP_MOD_MODE_BASE  = 8'hC0;
  localparam logic [7:0] CAP_VAL_LO_BASE    = 8'hC8;
  localparam logic [7:0] CAP_VAL_HI_BASE    = 8'hD0;

  // Control register fields.
  localparam int CAP_CTRL_OVF_BIT = 7;
  localparam int CAP_CTRL_RUN_BIT = 6;

  // Array mode register fields.
  localparam int CAP_ARR_OVF_IE_BIT = 0;

  // Module mode register fields.
  localparam int CAP_MODE_WIDE_BIT = 7;
  localparam int CAP_MODE_CMP_BIT  = 6;
  localparam int CAP_MODE_PWM_BIT  = 1;
  localparam int CAP_MODE_IE_BIT   = 0;

  // Values after reset, and the count at which the counter wraps.
  localparam logic [7:0]  CAP_CTRL_RST  = 8'h00;
  localparam logic [7:0]  CAP_MODE_RST  = 8'h00;
  localparam logic [15:0] CAP_CNT_RST   = 16'h0000;
  localparam logic [15:0] CAP_VAL_RST   = 16'h0000;
  localparam logic [15:0] CAP_CNT_MAX   = 16'hFFFF;
  localparam logic [7:0]  CAP_RD_UNMAP  = 8'h00;

  // True when addr selects the slot idx of a block of per-module registers.
  function automatic logic cap_hit(input logic [7:0] addr,
                                   input logic [7:0] base,
                                   input int         idx);
    cap_hit = (addr == 8'(base + idx[7:0]));
  endfunction

endpackage

/* File: test/cap_pwm_sink.sv */
// Load on one PWM pin that measures how long each level lasts.
`timescale 1ns/1ps
module cap_pwm_sink (
  input  wire logic clk_sys,
  input  wire logic pwm_in,
  output int        high_len,
  output int        low_len
);
  logic prev = 1'b0;
  int   run  = 0;

  // A level change closes the phase that the old level held.
  always @(posedge clk_sys) begin
    if (pwm_in !== prev) begin
      if (prev) high_len <= run;
      else low_len <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev <= pwm_in;
  end
endmodule

/* File: test/cap_top_monitor.sv */
// Port checks for the counter array top, bound to every instance.
`timescale 1ns/1ps
module cap_top_monitor
  import cap_pkg::*;
#(
  parameter int NUM_MOD = CAP_NUM_MOD,
  parameter int CNT_W   = CAP_CNT_W
) (
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic [7:0]         sfr_addr,
  input wire logic               sfr_wr,
  input wire logic [7:0]         sfr_wdata,
  input wire logic [NUM_MOD-1:0] pwm_output_n,
  input wire logic               overflow_irq_req,
  input wire logic               match_irq_req
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] val_r;
  logic [7:0]       mode_r;
  logic             run_r;
  logic             ie_r;
  logic [7:0]       wa;
  logic             wr_ctl;
  logic             wr_any;
  logic             wide;

  // Address of a write, or the unmapped zero when nothing is written.
  assign wa     = sfr_wr ? sfr_addr : 8'h00;
  assign wr_ctl = wa == CAP_CTRL_ADDR || wa == CAP_ARR_MODE_ADDR;
  assign wr_any = wr_ctl || wa inside {[8'hC0:8'hC5]};
  assign wide   = mode_r[7] && mode_r[6] && mode_r[1];

  // Software view of the counter; a byte write wins over counting.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      ie_r  <= 1'b0;
    end else begin
      if (wa == CAP_CTRL_ADDR) run_r <= sfr_wdata[6];
      if (wa == CAP_ARR_MODE_ADDR) ie_r <= sfr_wdata[0];
      if (wa == CAP_CNT_LO_ADDR) cnt_r[7:0] <= sfr_wdata;
      else if (wa == CAP_CNT_HI_ADDR) cnt_r[15:8] <= sfr_wdata;
      else if (run_r) cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Module 0 view, with the value byte side effects on compare enable.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= 8'h00;
      val_r  <= 16'h0000;
    end else begin
      if (wa == 8'hC0) mode_r <= sfr_wdata;
      else if (wa == 8'hC8) mode_r[6] <= 1'b0;
      else if (wa == 8'hD0) mode_r[6] <= 1'b1;
      if (wa == 8'hC8) val_r[7:0] <= sfr_wdata;
      if (wa == 8'hD0) val_r[15:8] <= sfr_wdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // A wrap, and a match of module 0, each in a cycle with no write.
  sequence s_wrap;
    run_r && cnt_r == 16'hFFFF && !sfr_wr;
  endsequence
  sequence s_hit;
    run_r && cnt_r == val_r && !sfr_wr && mode_r[6];
  endsequence

  property p_rst_quiet;
    $past(sys_rst) |-> pwm_output_n == '0 && !overflow_irq_req
      && !match_irq_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");

  property p_wrap_low;
    s_wrap ##0 val_r != 16'h0000 |-> ##3 !pwm_output_n[0];
  endproperty
  a_wrap_low: assert property (p_wrap_low)
    else $error("output not low after overflow");

  property p_hit_high;
    s_hit ##0 wide [*2] |-> ##1 pwm_output_n[0];
  endproperty
  a_hit_high: assert property (p_hit_high)
    else $error("output not high after match");

  property p_not_wide;
    !wide [*3] |=> !pwm_output_n[0];
  endproperty
  a_not_wide: assert property (p_not_wide)
    else $error("output active outside wide mode");

  property p_ovf_irq;
    s_wrap ##0 ie_r |-> ##[1:3] overflow_irq_req;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("no overflow request after wrap");

  property p_hit_irq;
    s_hit ##0 mode_r[0] |-> ##[1:3] match_irq_req;
  endproperty
  a_hit_irq: assert property (p_hit_irq)
    else $error("no match request after match");

  property p_ovf_hold;
    overflow_irq_req && !wr_ctl && !$past(wr_ctl) |=> overflow_irq_req;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow request dropped by itself");

  property p_hit_hold;
    match_irq_req && !wr_any && !$past(wr_any) |=> match_irq_req;
  endproperty
  a_hit_hold: assert property (p_hit_hold)
    else $error("match request dropped by itself");
endmodule

bind cap_top cap_top_monitor #(.NUM_MOD(NUM_MOD), .CNT_W(CNT_W)) mon_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .pwm_output_n(pwm_output_n),
  .overflow_irq_req(overflow_irq_req), .match_irq_req(match_irq_req));

/* File: test/test_cap_top.sv */
// Register level tests of the counter array top with a PWM load.
`timescale 1ns/1ps
module test_cap_top
  import cap_pkg::*;
;
  logic       clk_sys   = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [7:0] sfr_addr  = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic       sfr_rd    = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [5:0] pwm;
  logic       ovf_irq;
  logic       hit_irq;
  int         high_len;
  int         low_len;
  int         fail_count = 0;
  int         cmp_count  = 0;
  logic [7:0] idle_regs [7] = '{8'hD8, 8'hD9, 8'hC0, 8'hC8, 8'hD0,
                                8'hE8, 8'h00};

  always #5 clk_sys = ~clk_sys;

  cap_top cap_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pwm_output_n(pwm),
    .overflow_irq_req(ovf_irq), .match_irq_req(hit_irq));

  cap_pwm_sink cap_pwm_sink_i (.clk_sys(clk_sys), .pwm_in(pwm[0]),
    .high_len(high_len), .low_len(low_len));

  // Compare one observed value with the value worked out here.
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each access waits a falling edge first, so strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk_sys);
    sfr_wr    = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk_sys);
    sfr_rd   = 1'b0;
    check($sformatf("register %h", a), 16'(exp), 16'(sfr_rdata));
  endtask

  // Bounded wait for pin 0 to reach a level.
  task automatic wait_pin(input logic lvl, input int lim);
    int n = 0;
    while (pwm[0] !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    check("pin 0", 16'(lvl), 16'(pwm[0]));
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A full PWM period is 65536 cycles, so allow somewhat more.
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    check("outputs", 16'h0000, 16'({pwm, ovf_irq, hit_irq}));
    foreach (idle_regs[i]) rd(idle_regs[i], 8'h00);
    $display("test reset done");
    for (int n = 0; n < 6; n++) begin
      wr(8'hC0 + 8'(n), 8'hC3);
      wr(8'hC8 + 8'(n), 8'h10);
      rd(8'hC0 + 8'(n), 8'h83);
      wr(8'hD0 + 8'(n), 8'h00);
      rd(8'hC0 + 8'(n), 8'hC3);
    end
    wr(8'hC4, 8'hC1);
    wr(8'hC5, 8'h43);
    $display("test value bytes done");
    wr(8'hE8, 8'h34);
    wr(8'hE9, 8'h12);
    repeat (5) @(negedge clk_sys);
    rd(8'hE8, 8'h34);
    rd(8'hE9, 8'h12);
    wr(8'hE9, 8'h00);
    wr(8'hE8, 8'h00);
    $display("test stopped counter done");
    wr(8'hD9, 8'h01);
    wr(8'hD8, 8'h40);
    wait_pin(1'b1, 40);
    check("pins", 16'h000F, 16'(pwm));
    repeat (2) @(negedge clk_sys);
    check("match request", 16'h0001, 16'(hit_irq));
    rd(8'hD8, 8'h7F);
    wr(8'hC9, 8'h10);
    wr(8'hD1, 8'h00);
    wr(8'hD8, 8'h40);
    wait_pin(1'b0, 70000);
    rd(8'hD8, 8'hC0);
    check("high time", 16'hFFF0, 16'(high_len));
    check("overflow request", 16'h0001, 16'(ovf_irq));
    wait_pin(1'b1, 40);
    check("pins again", 16'h000F, 16'(pwm));
    rd(8'hD8, 8'hFF);
    check("low time", 16'h0010, 16'(low_len));
    wr(8'hD8, 8'h00);
    repeat (3) @(negedge clk_sys);
    check("requests", 16'h0000, 16'({ovf_irq, hit_irq}));
    rd(8'hD8, 8'h00);
    $display("test pwm period done");
    tally_and_finish();
  end
endmodule
